// ===== hw/rah_pkg.sv
// constants shared by the reserved-address controller and target ends
package rah_pkg;
   // ******************************
   // timing
   // ******************************
   localparam int CLK_HZ = 40000000;          // system clock rate
   localparam int SCL_HZ = 100000;            // bus bit rate in hertz
   localparam int QTR_CYC = CLK_HZ / (SCL_HZ * 4); // cycles per quarter bit
   // ******************************
   // reserved codes
   // ******************************
   localparam logic [7:0] GC_ADDR = 8'h00;    // broadcast address, write
   localparam logic [7:0] START_BYTE = 8'h01; // slow-receiver preamble
   localparam logic [7:0] GC_RESET = 8'h06;   // reset and latch address
   localparam logic [7:0] GC_LATCH = 8'h04;   // latch address only
   localparam logic [7:0] ID_WR = 8'hF8;      // identification, write
   localparam logic [7:0] ID_RD = 8'hF9;      // identification, read
   localparam int CLEAR_PULSES = 9;           // bus-clear clock count
   localparam int ID_BYTES = 3;               // identification length
   // ******************************
   // identification fields, values arbitrary
   // ******************************
   localparam logic [11:0] ID_MAKER = 12'h5A5; // arbitrary value
   localparam logic [8:0] ID_PART = 9'h0C3;    // arbitrary value
   localparam logic [2:0] ID_REV = 3'h1;       // arbitrary value
   // controller commands
   typedef enum logic [2:0] {RAH_CMD_START, RAH_CMD_BYTE, RAH_CMD_READ, RAH_CMD_STOP,
                             RAH_CMD_CLEAR} rah_cmd_t;
endpackage : rah_pkg

// ===== hw/rah_bus_if.sv
// two-wire bus between the controller end and the target end
`timescale 1ns/1ps
`default_nettype none
interface rah_bus_if;
   logic scl_o;   // controller clock drive value (low only)
   logic scl_oe;  // controller pulls clock low
   logic sda_c_oe; // controller pulls data low
   logic sda_t_oe; // target pulls data low
   logic scl;     // resolved clock line
   logic sda;     // resolved data line
   // wired-and resolution with pull-ups
   assign scl = ~scl_oe;
   assign sda = ~(sda_c_oe | sda_t_oe);
   modport ctrl (output scl_o, output scl_oe, output sda_c_oe, input scl, input sda);
   modport tgt (output sda_t_oe, input scl, input sda);
endinterface : rah_bus_if
`default_nettype wire

// ===== hw/rah_target.sv
// bus target decoding broadcast, start byte and identification reads
`timescale 1ns/1ps
`default_nettype none
module rah_target
   import rah_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   rah_bus_if.tgt bus,
   input wire logic [6:0] addr_strap,   // hardware address pins
   input wire logic gc_enable,          // respond to broadcast
   input wire logic slow_poll,          // model a polling receiver
   output logic [6:0] own_addr,         // latched target address
   output logic [6:0] hw_master_addr,   // last announced hardware master
   output logic hw_master_seen,         // pulse: hardware announcement
   output logic [6:0] dest_addr,        // destination taken in target mode
   output logic [7:0] rx_data,          // last byte received
   output logic rx_valid,               // pulse: byte accepted
   output logic soft_reset              // pulse: broadcast reset done
);
   // ******************************
   // line synchronisers
   // ******************************
   logic [1:0] scl_s; // scl_s[0] is first stage only
   logic [1:0] sda_s;
   logic scl_q;       // delayed synced clock
   logic sda_q;       // delayed synced data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_s <= {scl_s[0], bus.scl};
         sda_s <= {sda_s[0], bus.sda};
         scl_q <= scl_s[1];
         sda_q <= sda_s[1];
      end
   end
   wire scl_rise = scl_s[1] & ~scl_q;
   wire scl_fall = ~scl_s[1] & scl_q;
   wire start_det = scl_s[1] & scl_q & sda_q & ~sda_s[1];
   wire stop_det = scl_s[1] & scl_q & ~sda_q & sda_s[1];
   // ******************************
   // framing state
   // ******************************
   typedef enum {ST_IDLE, ST_ADDR, ST_GC2, ST_GCDATA, ST_HWDATA, ST_IDSEL, ST_IDRD, ST_DATA,
                 ST_IGNORE} rah_tst_t;
   rah_tst_t state;
   logic [3:0] bit_cnt;   // 0..7 data, 8 ack slot
   logic [7:0] shreg;     // receive shift register
   logic [7:0] tx_byte;   // identification byte being sent
   logic [1:0] id_idx;    // identification byte index
   logic id_armed;        // selected by identification write
   logic ack_pend;        // drive ack in coming slot
   logic tx_mode;         // sending identification bits
   logic bit_open;        // clock rose inside this frame; the fall after a start is not a bit
   logic [23:0] id_word;  // fixed identification
   // constant word, no write path exists
   assign id_word = {ID_MAKER, ID_PART, ID_REV};
   function automatic logic [7:0] id_byte(input logic [1:0] idx);
      id_byte = (idx == 2'h0) ? id_word[23:16] : (idx == 2'h1) ? id_word[15:8] : id_word[7:0];
   endfunction : id_byte
   // polling receiver sees activity only once data went low
   logic poll_awake;
   // slow sampling until a low bit
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         poll_awake <= 1'b0;
      end else if (!slow_poll || !sda_s[1]) begin
         poll_awake <= 1'b1;
      end else if (stop_det) begin
         poll_awake <= 1'b0;
      end
   end
   wire ack_byte = (bit_cnt == 4'h8);
   // ******************************
   // main receive and decode process
   // ******************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx_byte <= 8'h00;
         id_idx <= 2'h0;
         id_armed <= 1'b0;
         ack_pend <= 1'b0;
         tx_mode <= 1'b0;
         bit_open <= 1'b0;
         own_addr <= 7'h00;
         hw_master_addr <= 7'h00;
         hw_master_seen <= 1'b0;
         dest_addr <= 7'h00;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         hw_master_seen <= 1'b0;
         rx_valid <= 1'b0;
         soft_reset <= 1'b0;
         if (start_det && poll_awake) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            bit_open <= 1'b0;
            ack_pend <= 1'b0;
            tx_mode <= 1'b0;
         end else if (stop_det) begin
            // identification selection dies on stop
            state <= ST_IDLE;
            id_armed <= 1'b0;
            ack_pend <= 1'b0;
            tx_mode <= 1'b0;
         end else if (scl_rise && state != ST_IDLE) begin
            bit_open <= 1'b1;
            if (!ack_byte) begin
               shreg <= {shreg[6:0], sda_s[1]};
            end else if (tx_mode && !ack_pend) begin
               // own address ack slot is not a master answer
               // wrap or stop on master nack
               if (sda_s[1]) begin
                  tx_mode <= 1'b0;
                  state <= ST_IGNORE;
               end else begin
                  id_idx <= (id_idx == 2'(ID_BYTES - 1)) ? 2'h0 : id_idx + 2'h1;
               end
            end
         end else if (scl_fall && state != ST_IDLE && bit_open) begin
            // a fall with no rise since the start only ends the start
            bit_open <= 1'b0;
            if (bit_cnt == 4'h7 && !tx_mode) begin
               // byte complete: decide the ack
               bit_cnt <= 4'h8;
               unique case (state)
                  ST_ADDR: begin
                     if (shreg == GC_ADDR) begin
                        ack_pend <= gc_enable;
                        state <= gc_enable ? ST_GC2 : ST_IGNORE;
                     end else if (shreg == START_BYTE) begin
                        state <= ST_IGNORE;
                     end else if (shreg == ID_WR) begin
                        ack_pend <= 1'b1;
                        state <= ST_IDSEL;
                     end else if (shreg == ID_RD && id_armed) begin
                        ack_pend <= 1'b1;
                        tx_mode <= 1'b1;
                        id_idx <= 2'h0;
                        state <= ST_IDRD;
                     end else if (shreg[7:1] == own_addr && !shreg[0]) begin
                        ack_pend <= 1'b1;
                        state <= ST_DATA;
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end
                  ST_GC2: begin
                     if (shreg[0]) begin
                        hw_master_addr <= shreg[7:1];
                        hw_master_seen <= 1'b1;
                        ack_pend <= 1'b1;
                        state <= ST_HWDATA;
                     end else if (shreg == GC_RESET) begin
                        own_addr <= addr_strap;
                        soft_reset <= 1'b1;
                        ack_pend <= 1'b1;
                        state <= ST_GCDATA;
                     end else if (shreg == GC_LATCH) begin
                        own_addr <= addr_strap;
                        ack_pend <= 1'b1;
                        state <= ST_GCDATA;
                     end else begin
                        state <= ST_IGNORE;
                     end
                  end
                  ST_IDSEL: begin
                     // only the addressed target acks
                     ack_pend <= (shreg[7:1] == own_addr);
                     id_armed <= (shreg[7:1] == own_addr);
                     state <= ST_IGNORE;
                  end
                  ST_HWDATA, ST_DATA: begin
                     rx_data <= shreg;
                     rx_valid <= 1'b1;
                     dest_addr <= shreg[7:1];
                     ack_pend <= 1'b1;
                  end
                  default: begin
                     state <= ST_IGNORE;
                  end
               endcase
            end else if (ack_byte) begin
               // ack slot over, next byte
               bit_cnt <= 4'h0;
               ack_pend <= 1'b0;
               if (soft_reset || state == ST_GCDATA) begin
                  // after reset, back to idle released
                  state <= ST_IDLE;
               end
               if (tx_mode) begin
                  tx_byte <= id_byte(id_idx);
               end
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7) begin
                  bit_cnt <= 4'h8;
               end
               if (tx_mode) begin
                  tx_byte <= {tx_byte[6:0], 1'b0};
               end
            end
         end
         if (state == ST_ADDR && shreg == ID_RD && id_armed && scl_fall && bit_cnt == 4'h7) begin
            tx_byte <= id_byte(2'h0);
         end
      end
   end
   // ******************************
   // data line drive
   // ******************************
   // released from reset, never holds clock
   // data only held in ack or send slots
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bus.sda_t_oe <= 1'b0;
      end else if (start_det || stop_det) begin
         bus.sda_t_oe <= 1'b0;
      end else if (ack_byte) begin
         bus.sda_t_oe <= ack_pend;
      end else begin
         bus.sda_t_oe <= tx_mode & ~tx_byte[7];
      end
   end
endmodule : rah_target
`default_nettype wire

// ===== hw/rah_ctrl.sv
// bus controller issuing start, bytes, reads, stop and bus clear
`timescale 1ns/1ps
`default_nettype none
module rah_ctrl
   import rah_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   rah_bus_if.ctrl bus,
   input wire logic cmd_valid,      // command request
   output logic cmd_ready,          // idle, command taken
   input wire rah_cmd_t cmd,        // command code
   input wire logic [7:0] cmd_data, // byte to send
   input wire logic cmd_nack,       // read: answer nack
   output logic done,               // pulse: command finished
   output logic [7:0] rd_data,      // byte read
   output logic ack_seen            // ack sampled for last byte
);
   // ******************************
   // quarter-bit enable
   // ******************************
   logic [15:0] div;
   wire tick = (div == 16'(QTR_CYC - 1));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) div <= 16'h0000;
      else div <= tick ? 16'h0000 : div + 16'h0001;
   end
   // synced data line
   logic [1:0] sda_s;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) sda_s <= 2'h3;
      else sda_s <= {sda_s[0], bus.sda};
   end
   typedef enum {CS_IDLE, CS_RUN} rah_cst_t;
   rah_cst_t state;
   rah_cmd_t op;       // command in progress
   logic [1:0] ph;     // quarter phase
   logic [3:0] bitn;   // bit index, 8 is ack slot
   logic [7:0] sh;     // shift data
   logic nack_q;       // read ack answer
   assign cmd_ready = (state == CS_IDLE);
   assign bus.scl_o = 1'b0;
   // ******************************
   // sequencer: one bit slot is four quarters
   // ******************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= CS_IDLE;
         op <= RAH_CMD_STOP;
         ph <= 2'h0;
         bitn <= 4'h0;
         sh <= 8'h00;
         nack_q <= 1'b0;
         done <= 1'b0;
         rd_data <= 8'h00;
         ack_seen <= 1'b0;
         bus.scl_oe <= 1'b0;
         bus.sda_c_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         if (state == CS_IDLE && cmd_valid) begin
            state <= CS_RUN;
            op <= cmd;
            sh <= (cmd == RAH_CMD_READ) ? 8'hFF : cmd_data;
            nack_q <= cmd_nack;
            ph <= 2'h0;
            bitn <= 4'h0;
         end else if (state == CS_RUN && tick) begin
            ph <= ph + 2'h1;
            unique case (op)
               RAH_CMD_START: begin
                  // data high, clock high, data low, clock low
                  case (ph)
                     2'h0: bus.sda_c_oe <= 1'b0;
                     2'h1: bus.scl_oe <= 1'b0;
                     2'h2: bus.sda_c_oe <= 1'b1;
                     default: begin
                        bus.scl_oe <= 1'b1;
                        state <= CS_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
               RAH_CMD_STOP: begin
                  case (ph)
                     2'h0: bus.sda_c_oe <= 1'b1;
                     2'h1: bus.scl_oe <= 1'b0;
                     2'h2: bus.sda_c_oe <= 1'b0;
                     default: begin
                        state <= CS_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
               default: begin
                  // byte, read, or clear pulses
                  case (ph)
                     2'h0: begin
                        if (op == RAH_CMD_CLEAR) bus.sda_c_oe <= 1'b0;
                        else if (bitn == 4'h8) bus.sda_c_oe <= (op == RAH_CMD_READ) & ~nack_q;
                        else bus.sda_c_oe <= ~sh[7];
                     end
                     2'h1: bus.scl_oe <= 1'b0;
                     2'h2: begin
                        if (bitn == 4'h8) ack_seen <= ~sda_s[1];
                        else sh <= {sh[6:0], sda_s[1]};
                     end
                     default: begin
                        bus.scl_oe <= 1'b1;
                        bitn <= bitn + 4'h1;
                        if (bitn == 4'(CLEAR_PULSES - 1)) begin
                           state <= CS_IDLE;
                           done <= 1'b1;
                           bus.sda_c_oe <= 1'b0;
                           if (op == RAH_CMD_READ) rd_data <= sh;
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end
endmodule : rah_ctrl
`default_nettype wire

// ===== dv/rah_assertions.sv
// checker watching the two-wire bus between controller and target
`timescale 1ns/1ps
`default_nettype none
module rah_assertions (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_c_oe,
   input wire logic sda_t_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   // ******************************
   // bus decoder
   // ******************************
   logic scl_d; // clock one cycle ago
   logic sda_d; // data one cycle ago
   logic [3:0] bits; // clock rises since byte start
   logic [7:0] shreg; // bits shifted in, msb first
   logic first; // byte is the first after a start
   logic start_w; // data fell while clock high
   logic ack_rise; // clock rise of the ninth slot
   assign start_w = scl_d && scl && sda_d && !sda;
   assign ack_rise = scl && !scl_d && (bits == 4'h8);
   // line history, kept apart from the counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end
   // slot counter; bus clear pulses count too, harmless
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         bits <= 4'h0;
         shreg <= 8'h00;
         first <= 1'b0;
      end else if (start_w) begin
         bits <= 4'h0;
         first <= 1'b1;
      end else if (scl && !scl_d) begin
         if (bits == 4'h8) begin
            bits <= 4'h0;
            first <= 1'b0;
         end else begin
            bits <= bits + 4'h1;
            shreg <= {shreg[6:0], sda};
         end
      end
   end
   // ******************************
   // properties
   // ******************************
   a_released_after_reset: assert property ($rose(nrst) |-> !sda_t_oe && !sda_c_oe && !scl_oe)
      else $error("line held low right after reset");
   a_clock_drive_low: assert property (scl_oe |-> !scl_o)
      else $error("clock driven with a high value");
   a_target_rise_low: assert property ($rose(sda_t_oe) |-> !scl)
      else $error("target pulled data while clock high");
   a_target_hold_min: assert property ($rose(sda_t_oe) |-> sda_t_oe [*8])
      else $error("target drive shorter than eight cycles");
   a_target_stable_high: assert property (scl && $past(scl) |-> $stable(sda_t_oe))
      else $error("target changed data while clock high");
   a_start_byte_unacked: assert property (ack_rise && first && shreg == 8'h01 |-> sda)
      else $error("start byte was acknowledged");
   a_start_then_low: assert property (start_w |-> ##[1:200] !scl)
      else $error("clock not pulled low after start");
   a_clock_low_min: assert property ($fell(scl) |-> !scl [*8])
      else $error("clock low phase too short");
   c_start_byte: cover property (ack_rise && first && shreg == 8'h01);
   c_target_ack: cover property ($rose(sda_t_oe));
   c_start_seen: cover property (start_w);
endmodule : rah_assertions
`default_nettype wire

// ===== dv/tb_i2c_reserved_address_handler.sv
// self-checking bench joining the controller and target ends
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_reserved_address_handler;
   import rah_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cmd_valid = 1'b0;
   rah_cmd_t cmd = RAH_CMD_STOP;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_nack = 1'b0;
   logic [6:0] addr_strap = 7'h00;
   logic gc_enable = 1'b0;
   logic slow_poll = 1'b0;
   logic cmd_ready, done, ack_seen, hw_master_seen, soft_reset, rx_valid;
   logic [7:0] rd_data, rx_data;
   logic [6:0] own_addr, hw_master_addr, dest_addr;
   int mismatches = 0;
   int num_checks = 0;
   int n_reset = 0; // broadcast reset pulses
   int n_hw = 0; // hardware announcement pulses
   int n_rx = 0; // accepted data byte pulses
   logic [23:0] id_word = {ID_MAKER, ID_PART, ID_REV};
   always #12.5 clk = ~clk;
   rah_bus_if i_rah_bus_if ();
   rah_ctrl i_rah_ctrl (.clk(clk), .nrst(nrst), .bus(i_rah_bus_if.ctrl), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .done(done),
      .rd_data(rd_data), .ack_seen(ack_seen));
   rah_target i_rah_target (.clk(clk), .nrst(nrst), .bus(i_rah_bus_if.tgt), .addr_strap(addr_strap),
      .gc_enable(gc_enable), .slow_poll(slow_poll), .own_addr(own_addr), .hw_master_addr(hw_master_addr),
      .hw_master_seen(hw_master_seen), .dest_addr(dest_addr), .rx_data(rx_data), .rx_valid(rx_valid),
      .soft_reset(soft_reset));
   rah_assertions i_rah_assertions (.clk(clk), .nrst(nrst), .scl_o(i_rah_bus_if.scl_o),
      .scl_oe(i_rah_bus_if.scl_oe), .sda_c_oe(i_rah_bus_if.sda_c_oe), .sda_t_oe(i_rah_bus_if.sda_t_oe),
      .scl(i_rah_bus_if.scl), .sda(i_rah_bus_if.sda));
   // ******************************
   // helpers
   // ******************************
   // one-cycle pulses are counted so scenarios can judge them afterwards
   always @(posedge clk) begin
      if (soft_reset === 1'b1) n_reset++;
      if (hw_master_seen === 1'b1) n_hw++;
      if (rx_valid === 1'b1) n_rx++;
   end
   task automatic tally_and_finish;
      if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // wait for idle, hold the request across the taking edge, then wait done
   task automatic run(input rah_cmd_t c, input logic [7:0] d, input logic n);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         #2;
      end while (cmd_ready !== 1'b1);
      cmd = c;
      cmd_data = d;
      cmd_nack = n;
      cmd_valid = 1'b1;
      @(posedge clk);
      #2;
      cmd_valid = 1'b0;
      while (done !== 1'b1 && k < 5000) begin
         @(posedge clk);
         #2;
         k++;
      end
      if (k >= 5000) chk(8'h00, 8'hFF);
   endtask : run
   // send one byte and judge the acknowledge slot
   task automatic wr(input logic [7:0] d, input logic a);
      run(RAH_CMD_BYTE, d, 1'b0);
      chk({7'h00, ack_seen}, {7'h00, a});
   endtask : wr
   // ******************************
   // scenarios
   // ******************************
   task automatic sc_gc_latch;
      int n0;
      n0 = n_reset;
      gc_enable = 1'b1;
      addr_strap = 7'h2A;
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(GC_ADDR, 1'b1);
      wr(GC_LATCH, 1'b1);
      chk({1'b0, own_addr}, 8'h2A);
      chk(8'(n_reset - n0), 8'h00);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
   endtask : sc_gc_latch
   task automatic sc_gc_reset;
      int n0;
      n0 = n_reset;
      addr_strap = 7'h15;
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(GC_ADDR, 1'b1);
      wr(GC_RESET, 1'b1);
      chk({1'b0, own_addr}, 8'h15);
      chk(8'(n_reset - n0), 8'h01);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
      chk({7'h00, i_rah_bus_if.sda}, 8'h01);
   endtask : sc_gc_reset
   // disabled broadcast is left unacked; undefined even codes change nothing
   task automatic sc_gc_ignore;
      gc_enable = 1'b0;
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(GC_ADDR, 1'b0);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
      gc_enable = 1'b1;
      addr_strap = 7'h2A;
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(GC_ADDR, 1'b1);
      run(RAH_CMD_BYTE, 8'h08, 1'b0);
      chk({1'b0, own_addr}, 8'h15);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
   endtask : sc_gc_ignore
   task automatic sc_hw_call;
      int n0;
      int n1;
      n0 = n_hw;
      n1 = n_rx;
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(GC_ADDR, 1'b1);
      run(RAH_CMD_BYTE, 8'h37, 1'b0);
      chk({1'b0, hw_master_addr}, 8'h1B);
      chk(8'(n_hw - n0), 8'h01);
      run(RAH_CMD_BYTE, 8'h50, 1'b0);
      chk({1'b0, dest_addr}, 8'h28);
      chk(rx_data, 8'h50);
      chk(8'(n_rx - n1), 8'h01);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
   endtask : sc_hw_call
   // slow receiver must still catch the repeated start after the preamble
   task automatic sc_start_byte;
      slow_poll = 1'b1;
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(START_BYTE, 1'b0);
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(GC_ADDR, 1'b1);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
      slow_poll = 1'b0;
   endtask : sc_start_byte
   // reads wrap past the third byte; target then shifts out the next byte until the clear pulses reach its ack slot
   task automatic sc_id_read;
      run(RAH_CMD_START, 8'h00, 1'b0);
      run(RAH_CMD_BYTE, ID_WR, 1'b0);
      wr({7'h16, 1'b0}, 1'b0);
      run(RAH_CMD_START, 8'h00, 1'b0);
      run(RAH_CMD_BYTE, ID_WR, 1'b0);
      wr({7'h15, 1'b0}, 1'b1);
      run(RAH_CMD_START, 8'h00, 1'b0);
      wr(ID_RD, 1'b1);
      for (int i = 0; i < ID_BYTES + 1; i++) begin
         run(RAH_CMD_READ, 8'h00, 1'b0);
         chk(rd_data, id_word[8 * (2 - i % 3) +: 8]);
      end
      run(RAH_CMD_CLEAR, 8'h00, 1'b0);
      chk({7'h00, i_rah_bus_if.sda}, 8'h01);
      run(RAH_CMD_STOP, 8'h00, 1'b0);
   endtask : sc_id_read
   // ******************************
   // main sequence and watchdog
   // ******************************
   initial begin
      repeat (4) @(posedge clk);
      #2;
      nrst = 1'b1;
      sc_gc_latch();
      sc_gc_reset();
      sc_gc_ignore();
      sc_hw_call();
      sc_start_byte();
      sc_id_read();
      tally_and_finish();
   end
   // about a sixth above the worst-case run length
   initial begin
      #(25 * 100000);
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_i2c_reserved_address_handler
`default_nettype wire
